// ---- rtl/ptt_regs.sv ----
// Overview of operation
// R1 - Zero toggle bits cause no action
// R2 - Set and clear together means clear
// R3 - Bit 6 reinitialises ramp RAM pointer
// R4 - Bit 5 reinitialises burst buffer B pointer
// R5 - Bit 4 reinitialises burst buffer A pointer
// R6 - Software avoids buffer strobes during uplink burst
// R7 - Bits 3/2 set/clear master clock active
// R8 - Bits 1/0 set/clear converter hold on
// R9 - Clock inactive selects low power slow clock
// R10 - Hold on converter_hold_set ADC powered
// R11 - Hold off lets ADC switch off
// R12 - Toggle one bits 9/8 drive monitor power
// R13 - Toggle one bits 7/6 drive AFC power
// R14 - Toggle one bits 5/4 drive aux DAC
// R15 - Toggle one bits 3/2 drive voice down
// R16 - Toggle one bits 1/0 drive voice up
// R17 - Control bit one selects register instruction
// R18 - Control bit zero selects JTAG shift instruction
// R19 - Instruction field bits 5-0, reset zero
// R20 - Bits 9-6 read fixed version nibble
// R21 - Software enables both voice paths together
// R22 - Reserved bits ignored and read zero
//
// Decided for this implementation: register access over APB.
`default_nettype none
module ptt_regs (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Test access
    input  wire logic [ptt_pkg::PTT_IR_W-1:0] jtag_shift_instr,
    output logic [ptt_pkg::PTT_IR_W-1:0]    active_test_mode,
    // Controlled blocks
    output ptt_pkg::ptt_power_s             power_latches,
    output logic                            low_power_slow_clk,
    output logic                            monitor_adc_auto_off,
    output logic                            ramp_ram_pointer_init,
    output logic                            burst_buf_b_pointer_init,
    output logic                            burst_buf_a_pointer_init
);
    import ptt_pkg::*;

    // Bus phase qualifiers
    logic                   setup_phase;
    logic                   access_phase;
    logic                   wr_en;
    logic                   rd_en;

    // Address decode, one select per register
    logic                   addr_in_range;
    logic                   sel_tog1;
    logic                   sel_tog2;
    logic                   sel_status;
    logic                   sel_test_ctrl;
    logic                   sel_test_instr;
    logic                   hit;

    // Per-register write enables
    logic                   wr_tog1_en;
    logic                   wr_tog2_en;
    logic                   wr_ctrl_en;
    logic                   wr_instr_en;

    // Toggle strobes, alive for the write cycle only
    logic [PTT_REG_W-1:0]   wr_tog1;
    logic [PTT_REG_W-1:0]   wr_tog2;
    logic [PTT_NUM_PWR-1:0] pwr_set;
    logic [PTT_NUM_PWR-1:0] pwr_clr;

    // Toggle two decode
    logic                   mclk_set;
    logic                   mclk_clr;
    logic                   hold_set;
    logic                   hold_clr;
    logic                   ramp_req;
    logic                   bufb_req;
    logic                   bufa_req;

    // Latches and strobe registers
    logic [PTT_NUM_PWR-1:0] pwr_r;
    logic                   mclk_act_r;
    logic                   hold_on_r;
    logic                   ramp_init_r;
    logic                   bufb_init_r;
    logic                   bufa_init_r;

    // Test access state
    logic                   test_mode_by_register_r;
    logic [PTT_IR_W-1:0]    instruction_field_r;
    logic [PTT_IR_W-1:0]    mode_src;
    logic [PTT_IR_W-1:0]    active_mode_r;

    // Read path
    logic [PTT_REG_W-1:0]   status_word;
    logic [PTT_REG_W-1:0]   instr_word;
    logic [PTT_REG_W-1:0]   rd_word;
    logic [31:0]            prdata_r;

    // Single-cycle access phase; never stalls the master
    assign pready        = 1'b1;

    // Phase qualifiers shared by decode and strobes
    assign setup_phase   = psel && !penable;
    assign access_phase  = psel && penable;
    // Writes land in the access phase only
    assign wr_en         = access_phase && pwrite;
    // Reads capture in setup so data stands through access
    // An unmapped read therefore returns zero
    assign rd_en         = setup_phase && !pwrite;
    // Upper address bits must be zero for any hit
    assign addr_in_range = (paddr[11:10] == 2'b00);

    // Address map, byte address four times the index:
    // index 0x04 toggle one, 0x05 toggle two,
    // 0x09 status, 0x13 test control, 0x14 test instruction
    // Toggle one sits beside toggle two as it feeds the power latches
    always_comb begin
        sel_tog1       = 1'b0;
        sel_tog2       = 1'b0;
        sel_status     = 1'b0;
        sel_test_ctrl  = 1'b0;
        sel_test_instr = 1'b0;
        if (!addr_in_range) begin
            sel_tog1       = 1'b0;
        end else if (paddr[9:0] == PTT_ADDR_TOGGLE_ONE) begin
            sel_tog1       = 1'b1;
        end else if (paddr[9:0] == PTT_ADDR_TOGGLE_TWO) begin
            sel_tog2       = 1'b1;
        end else if (paddr[9:0] == PTT_ADDR_PWDN_STATUS) begin
            sel_status     = 1'b1;
        end else if (paddr[9:0] == PTT_ADDR_TEST_CTRL) begin
            sel_test_ctrl  = 1'b1;
        end else if (paddr[9:0] == PTT_ADDR_TEST_INSTR) begin
            sel_test_instr = 1'b1;
        end
    end
    assign hit = sel_tog1
              || sel_tog2
              || sel_status
              || sel_test_ctrl
              || sel_test_instr;

    // Unmapped or above-range addresses flag an error
    // A refused access changes no state
    always_comb begin
        pslverr = 1'b0;
        if (access_phase && !hit) begin
            pslverr = 1'b1;
        end
    end

    // Write enables per register
    assign wr_tog1_en  = wr_en && sel_tog1;
    assign wr_tog2_en  = wr_en && sel_tog2;
    assign wr_ctrl_en  = wr_en && sel_test_ctrl;
    assign wr_instr_en = wr_en && sel_test_instr;

    // Toggle strobes exist only for the write cycle; nothing is stored
    // R22 - bits 31:10 never reach a strobe
    always_comb begin
        wr_tog1 = '0;
        wr_tog2 = '0;
        if (wr_tog1_en) begin
            // R12 R13 R14 R15 R16 - power strobes
            wr_tog1 = pwdata[PTT_REG_W-1:0];
        end
        if (wr_tog2_en) begin
            // R3 R4 R5 R7 R8 - latch and pointer strobes
            wr_tog2 = pwdata[PTT_REG_W-1:0];
        end
    end

    // R7 R8 - latch requests from toggle two
    assign mclk_set = wr_tog2[PTT_T2_MCLK_SET];
    assign mclk_clr = wr_tog2[PTT_T2_MCLK_CLR];
    assign hold_set = wr_tog2[PTT_T2_HOLD_SET];
    assign hold_clr = wr_tog2[PTT_T2_HOLD_CLR];

    // R3 R4 R5 - pointer requests; bits 9:7 reserved, unused
    assign ramp_req = wr_tog2[PTT_T2_RAMP_PTR];
    assign bufb_req = wr_tog2[PTT_T2_BUFB_PTR];
    assign bufa_req = wr_tog2[PTT_T2_BUFA_PTR];

    // Pairs in toggle one: set at odd bit, clear at even bit
    // Clear tested first, so set plus clear in one write reads as clear
    genvar g;
    generate
        for (g = 0; g < PTT_NUM_PWR; g++) begin : g_pwr
            assign pwr_set[g] = wr_tog1[2*g+1];
            assign pwr_clr[g] = wr_tog1[2*g];
            // R12 R13 R14 R15 R16 - power latches
            // R1 R2 - zero no-op, clear wins
            always_ff @(posedge mclk) begin
                if (rst) begin
                    pwr_r[g] <= 1'b0;
                end else if (pwr_clr[g]) begin
                    pwr_r[g] <= 1'b0;
                end else if (pwr_set[g]) begin
                    pwr_r[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // R7 R2 - master clock latch
    always_ff @(posedge mclk) begin
        if (rst) begin
            mclk_act_r <= 1'b0;
        end else if (mclk_clr) begin
            mclk_act_r <= 1'b0; // Clear before set
        end else if (mclk_set) begin
            mclk_act_r <= 1'b1;
        end
    end

    // R8 R2 - converter hold latch
    always_ff @(posedge mclk) begin
        if (rst) begin
            hold_on_r <= 1'b0;
        end else if (hold_clr) begin
            hold_on_r <= 1'b0; // Clear before set
        end else if (hold_set) begin
            hold_on_r <= 1'b1;
        end
    end

    // Pointer strobes: one-cycle pulses, registered for clean timing
    // Uplink burst state is not seen here, so misuse is not caught
    // R3 - ramp pointer reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            ramp_init_r <= 1'b0;
        end else begin
            ramp_init_r <= ramp_req;
        end
    end

    // R4 - buffer B pointer
    always_ff @(posedge mclk) begin
        if (rst) begin
            bufb_init_r <= 1'b0;
        end else begin
            bufb_init_r <= bufb_req;
        end
    end

    // R5 - buffer A pointer
    always_ff @(posedge mclk) begin
        if (rst) begin
            bufa_init_r <= 1'b0;
        end else begin
            bufa_init_r <= bufa_req;
        end
    end

    // R17 R18 - source select bit
    always_ff @(posedge mclk) begin
        if (rst) begin
            test_mode_by_register_r <= 1'b0;
        end else if (wr_ctrl_en) begin
            // R22 - only bit 0 kept
            test_mode_by_register_r <= pwdata[0];
        end
    end

    // R19 - instruction field write
    always_ff @(posedge mclk) begin
        if (rst) begin
            instruction_field_r <= PTT_IR_RESET;
        end else if (wr_instr_en) begin
            instruction_field_r <= pwdata[PTT_IR_W-1:0];
        end
    end

    // Test mode source select
    always_comb begin
        if (test_mode_by_register_r) begin
            // R17 - register instruction
            mode_src = instruction_field_r;
        end else begin
            // R18 - JTAG shift source
            mode_src = jtag_shift_instr;
        end
    end

    // Registered so the mode never glitches; one cycle of lag
    always_ff @(posedge mclk) begin
        if (rst) begin
            active_mode_r <= PTT_IR_RESET;
        end else begin
            active_mode_r <= mode_src;
        end
    end

    // R22 - status word, reserved bits zero
    always_comb begin
        status_word               = '0;
        status_word[PTT_ST_MCLK]  = mclk_act_r;
        status_word[PTT_ST_HOLD]  = hold_on_r;
        status_word[PTT_ST_MON:0] = pwr_r;
    end

    // R20 - fixed version above instruction field
    assign instr_word = {PTT_VERSION, instruction_field_r};

    // Read mux; write-only registers read as zero
    always_comb begin
        rd_word = '0;
        if (sel_tog1 || sel_tog2) begin
            // R1 - strobes hold no value
            rd_word = '0;
        end else if (sel_status) begin
            rd_word = status_word;
        end else if (sel_test_ctrl) begin
            // Select bit is write-only
            rd_word = '0;
        end else if (sel_test_instr) begin
            rd_word = instr_word;
        end
    end

    // Read data captured in setup, valid through the access phase
    // Bits above the register width always read zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_r <= {22'h00_0000, rd_word};
        end
    end
    assign prdata = prdata_r;

    // Status to controlled blocks, one field per latch
    always_comb begin
        power_latches                    = '0;
        power_latches.master_clk_active  = mclk_act_r;
        power_latches.converter_hold_on  = hold_on_r;
        power_latches.monitor_conv_power = pwr_r[PTT_ST_MON];
        power_latches.freq_ctrl_power    = pwr_r[PTT_ST_AFC];
        power_latches.aux_dac_power      = pwr_r[PTT_ST_ADAC];
        power_latches.voice_down_power   = pwr_r[PTT_ST_VDOWN];
        power_latches.voice_up_power     = pwr_r[PTT_ST_VUP];
    end

    // R9 - slow clock while inactive
    assign low_power_slow_clk   = !mclk_act_r;
    // R10 R11 - ADC auto power-off
    assign monitor_adc_auto_off = !hold_on_r;
    // R17 R18 - selected test mode out
    assign active_test_mode     = active_mode_r;

    // Pointer strobes out; each pulse lasts one clock
    assign ramp_ram_pointer_init    = ramp_init_r;
    assign burst_buf_b_pointer_init = bufb_init_r;
    assign burst_buf_a_pointer_init = bufa_init_r;
endmodule
`default_nettype wire

// ---- rtl/ptt_pkg.sv ----
`default_nettype none
package ptt_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] PTT_IDX_TOGGLE_TWO  = 8'h05;
    localparam logic [7:0] PTT_IDX_PWDN_STATUS = 8'h09;
    localparam logic [7:0] PTT_IDX_TEST_CTRL   = 8'h13;
    localparam logic [7:0] PTT_IDX_TEST_INSTR  = 8'h14;
    localparam logic [7:0] PTT_IDX_TOGGLE_ONE  = 8'h04;
    localparam logic [9:0] PTT_ADDR_TOGGLE_TWO  = {PTT_IDX_TOGGLE_TWO, 2'b00};
    localparam logic [9:0] PTT_ADDR_PWDN_STATUS = {PTT_IDX_PWDN_STATUS, 2'b00};
    localparam logic [9:0] PTT_ADDR_TEST_CTRL   = {PTT_IDX_TEST_CTRL, 2'b00};
    localparam logic [9:0] PTT_ADDR_TEST_INSTR  = {PTT_IDX_TEST_INSTR, 2'b00};
    localparam logic [9:0] PTT_ADDR_TOGGLE_ONE  = {PTT_IDX_TOGGLE_ONE, 2'b00};

    // Toggle register one bit positions
    localparam int PTT_T1_MON_SET  = 9;
    localparam int PTT_T1_MON_CLR  = 8;
    // Toggle register two bit positions
    localparam int PTT_T2_RAMP_PTR = 6;
    localparam int PTT_T2_BUFB_PTR = 5;
    localparam int PTT_T2_BUFA_PTR = 4;
    localparam int PTT_T2_MCLK_SET = 3;
    localparam int PTT_T2_MCLK_CLR = 2;
    localparam int PTT_T2_HOLD_SET = 1;
    localparam int PTT_T2_HOLD_CLR = 0;
    // Status word bit positions
    localparam int PTT_ST_MCLK   = 6;
    localparam int PTT_ST_HOLD   = 5;
    localparam int PTT_ST_MON    = 4;
    localparam int PTT_ST_AFC    = 3;
    localparam int PTT_ST_ADAC   = 2;
    localparam int PTT_ST_VDOWN  = 1;
    localparam int PTT_ST_VUP    = 0;
    localparam int PTT_NUM_PWR   = 5;
    localparam int PTT_REG_W     = 10;
    localparam int PTT_IR_W      = 6;
    localparam int PTT_VER_LSB   = 6;

    localparam logic [PTT_IR_W-1:0] PTT_IR_RESET = 6'h00;
    // Arbitrary neutral version value
    localparam logic [3:0]          PTT_VERSION  = 4'h1;

    // Power latches travelling together
    typedef struct packed {
        logic master_clk_active;
        logic converter_hold_on;
        logic monitor_conv_power;
        logic freq_ctrl_power;
        logic aux_dac_power;
        logic voice_down_power;
        logic voice_up_power;
    } ptt_power_s;
endpackage
`default_nettype wire

// ---- bench/ptt_regs_asserts.sv ----
`default_nettype none
module ptt_regs_chk (
    // Clock, reset and bus
    input wire logic                mclk,
    input wire logic                rst,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    // Latches and strobes
    input wire ptt_pkg::ptt_power_s power_latches,
    input wire logic                ramp_ram_pointer_init,
    input wire logic                burst_buf_b_pointer_init,
    input wire logic                burst_buf_a_pointer_init
);
    import ptt_pkg::*;
    logic       wr1;
    logic       wr2;
    logic [2:0] ptr;
    ptt_power_s pl;
    // Access-phase writes; pready is tied high so each lands once
    assign wr1 = psel && penable && pwrite && paddr == {2'h0, PTT_ADDR_TOGGLE_ONE};
    assign wr2 = psel && penable && pwrite && paddr == {2'h0, PTT_ADDR_TOGGLE_TWO};
    assign ptr = {ramp_ram_pointer_init, burst_buf_b_pointer_init, burst_buf_a_pointer_init};
    assign pl = power_latches;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_ptr; wr2 |=> ptr == $past(pwdata[6:4]); endproperty
    property p_idle; !wr2 |=> ptr == 3'h0; endproperty
    property p_mset; wr2 && pwdata[3] && !pwdata[2] |=> pl.master_clk_active; endproperty
    property p_mclr; wr2 && pwdata[2] |=> !pl.master_clk_active; endproperty
    property p_hset; wr2 && pwdata[1] && !pwdata[0] |=> pl.converter_hold_on; endproperty
    property p_hclr; wr2 && pwdata[0] |=> !pl.converter_hold_on; endproperty
    property p_mon; wr1 && pwdata[8] |=> !pl.monitor_conv_power; endproperty
    property p_keep; !wr1 && !wr2 |=> $stable(pl); endproperty
    property p_mons; wr1 && pwdata[9] && !pwdata[8] |=> pl.monitor_conv_power; endproperty
    a_ptr: assert property (p_ptr) else $error("pointer strobe mismatch");
    a_idle: assert property (p_idle) else $error("stray pointer strobe");
    a_mset: assert property (p_mset) else $error("clock latch not set");
    a_mclr: assert property (p_mclr) else $error("clock latch not cleared");
    a_hset: assert property (p_hset) else $error("hold latch not set");
    a_hclr: assert property (p_hclr) else $error("hold latch not cleared");
    a_mon: assert property (p_mon) else $error("monitor power not cleared");
    a_keep: assert property (p_keep) else $error("latch moved unasked");
    a_mons: assert property (p_mons) else $error("monitor power not set");
endmodule
bind ptt_regs ptt_regs_chk u_chk (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .power_latches(power_latches),
    .ramp_ram_pointer_init(ramp_ram_pointer_init),
    .burst_buf_b_pointer_init(burst_buf_b_pointer_init),
    .burst_buf_a_pointer_init(burst_buf_a_pointer_init));
`default_nettype wire

// ---- bench/ptt_apb_host.sv ----
`default_nettype none
module ptt_apb_host (
    // Clock
    input wire logic        mclk,
    // APB master
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [11:0]     paddr,
    output logic [31:0]     pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus from time zero
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // no uplink burst here
    // Entered just after an edge; held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data must not keep the old word
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_power_toggle_and_test_regs.sv ----
`default_nettype none
module tb_power_toggle_and_test_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import ptt_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [5:0]  jtag = 6'h2a;
    logic [5:0]  mode;
    ptt_power_s  pl;
    logic        slow, auto_off, ramp, bufb, bufa;
    int          mismatches = 0;
    int          check_count = 0;
    int          cyc = 0;
    always #5 mclk = ~mclk;
    ptt_regs dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .jtag_shift_instr(jtag), .active_test_mode(mode), .power_latches(pl),
        .low_power_slow_clk(slow), .monitor_adc_auto_off(auto_off),
        .ramp_ram_pointer_init(ramp), .burst_buf_b_pointer_init(bufb),
        .burst_buf_a_pointer_init(bufa));
    ptt_apb_host host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus helpers leave one idle edge so no signal is driven twice at once
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rdv, err);
        @(posedge mclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rdv, err);
        chk(rdv, exp);
        @(posedge mclk);
    endtask
    task automatic t_reset;
        rd(PTT_ADDR_PWDN_STATUS, 32'h0);
        rd(PTT_ADDR_TOGGLE_TWO, 32'h0);
        rd(PTT_ADDR_TEST_INSTR, {22'h0, PTT_VERSION, 6'h00});
    endtask
    task automatic t_pwr;
        for (int i = 0; i < PTT_NUM_PWR; i++) begin
            wr(PTT_ADDR_TOGGLE_ONE, 32'h2 << (2 * i));
            rd(PTT_ADDR_PWDN_STATUS, 32'h1 << i);
            wr(PTT_ADDR_TOGGLE_ONE, 32'h3 << (2 * i));
            rd(PTT_ADDR_PWDN_STATUS, 32'h0);
        end
        wr(PTT_ADDR_TOGGLE_ONE, 32'hffff_feaa); // all five power sets at once, both voice paths included
        wr(PTT_ADDR_TOGGLE_ONE, 32'h0);
        rd(PTT_ADDR_PWDN_STATUS, 32'h1f);
        wr(PTT_ADDR_TOGGLE_ONE, 32'h155);
        rd(PTT_ADDR_PWDN_STATUS, 32'h0);
    endtask
    task automatic t_t2;
        wr(PTT_ADDR_TOGGLE_TWO, 32'h8);
        chk(err, 1'b0);
        rd(PTT_ADDR_PWDN_STATUS, 32'h40);
        chk(slow, 1'b0);
        wr(PTT_ADDR_TOGGLE_TWO, 32'h382);
        rd(PTT_ADDR_PWDN_STATUS, 32'h60);
        chk(auto_off, 1'b0);
        wr(PTT_ADDR_TOGGLE_TWO, 32'hf);
        rd(PTT_ADDR_PWDN_STATUS, 32'h0);
        chk({slow, auto_off}, 2'b11);
    endtask
    task automatic t_ptr;
        for (int b = 4; b < 7; b++) begin
            host.xfer(1'b1, PTT_ADDR_TOGGLE_TWO, 32'h1 << b, rdv, err);
            #1;
            chk({ramp, bufb, bufa}, 32'h1 << (b - 4));
            @(posedge mclk);
            #1;
            chk({ramp, bufb, bufa}, 3'h0);
            @(posedge mclk);
        end
    endtask
    task automatic t_tap;
        wr(PTT_ADDR_TEST_INSTR, 32'hffff_ffff);
        rd(PTT_ADDR_TEST_INSTR, {22'h0, PTT_VERSION, 6'h3f});
        chk(mode, 6'h2a);
        wr(PTT_ADDR_TEST_CTRL, 32'h1);
        @(posedge mclk);
        chk(mode, 6'h3f);
        rd(PTT_ADDR_TEST_CTRL, 32'h0);
        jtag <= 6'h15;
        wr(PTT_ADDR_TEST_CTRL, 32'h0);
        @(posedge mclk);
        chk(mode, 6'h15);
    endtask
    task automatic t_unmapped;
        wr(12'hc14, 32'h3ff);
        chk(err, 1'b1);
        rd(PTT_ADDR_PWDN_STATUS, 32'h0);
    endtask
    // Mid-run reset clears every latch and the instruction field
    task automatic t_rerst;
        wr(PTT_ADDR_TOGGLE_ONE, 32'h2aa);
        wr(PTT_ADDR_TOGGLE_TWO, 32'ha);
        rd(PTT_ADDR_PWDN_STATUS, 32'h7f);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk({pl, slow, auto_off}, 9'h003);
        rd(PTT_ADDR_PWDN_STATUS, 32'h0);
        rd(PTT_ADDR_TEST_INSTR, {22'h0, PTT_VERSION, 6'h00});
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            close_out;
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset;
        t_pwr;
        t_t2;
        t_ptr;
        t_tap;
        t_unmapped;
        t_rerst;
        close_out;
    end
endmodule
`default_nettype wire
